/* File: common/aux_port_pkg.sv */
package aux_port_pkg;

	// ------------------------------------------------------------------
	// command bytes (sent with the register select low)
	// ------------------------------------------------------------------
	localparam logic [7:0] CMD_CONFIGURE = 8'hf4;
	localparam logic [7:0] CMD_STATUS    = 8'hf5;
	localparam logic [7:0] CMD_SEND      = 8'hf6;
	localparam logic [7:0] CMD_READ      = 8'hf7;
	localparam logic [7:0] CMD_BUF_SEND  = 8'hf8;

	// ------------------------------------------------------------------
	// connector line positions
	// ------------------------------------------------------------------
	localparam int NUM_LINES = 7;
	localparam int LN_SCK    = 0;
	localparam int LN_RXD    = 1;
	localparam int LN_MOSI   = 2;
	localparam int LN_MISO   = 3;
	localparam int LN_TXD    = 4;
	localparam int LN_MB     = 5;
	localparam int LN_HB     = 6;

	// ------------------------------------------------------------------
	// configuration byte fields
	// ------------------------------------------------------------------
	localparam int CFG_IO_BIT       = 7;
	localparam int CFG_ASYNC_BIT    = 6;
	localparam int CFG_LEVEL_BIT    = 5;
	localparam int CFG_BUSY_WAIT    = 4;
	localparam int CFG_IDLE_CLK_BIT = 3;
	localparam int CFG_EDGE_BIT     = 2;
	localparam int CFG_PAR_EN_BIT   = 3;
	localparam int CFG_PAR_ODD_BIT  = 2;
	localparam logic [6:0] RST_LINE_DIR = 7'h7f;

	// ------------------------------------------------------------------
	// status byte fields
	// ------------------------------------------------------------------
	localparam int ST_HB_BIT   = 4;
	localparam int ST_PEND_BIT = 3;
	localparam int ST_TXC_BIT  = 2;
	localparam int ST_RXC_BIT  = 1;
	localparam int ST_ERR_BIT  = 0;

	// ------------------------------------------------------------------
	// buffer and timing
	// ------------------------------------------------------------------
	localparam logic [7:0] BUF_DEPTH = 8'h80;
	localparam int LINK_HZ  = 12_500_000;
	localparam int SPI_HZ_0 = 4_000_000;
	localparam int SPI_HZ_1 = 1_000_000;
	localparam int SPI_HZ_2 = 250_000;
	localparam int SPI_HZ_3 = 125_000;
	localparam int BAUD_0   = 4800;
	localparam int BAUD_1   = 9600;
	localparam int BAUD_2   = 19200;
	localparam int BAUD_3   = 38400;
	localparam int CNT_W    = 12;

	typedef enum logic [1:0] {MODE_IO, MODE_SYNC, MODE_ASYNC} port_mode_t;

	typedef struct packed {
		port_mode_t  mode;
		logic        idle_hi;
		logic        edge_rise;
		logic [1:0]  speed;
		logic        par_en;
		logic        par_odd;
		logic [1:0]  baud;
	} link_cfg_t;

	typedef struct packed {
		logic        valid;
		logic        rs;
		logic [7:0]  data;
	} host_wr_t;

	// half clock period in link cycles, rounded up so the rate is a ceiling
	function automatic logic [CNT_W-1:0] spi_half(input logic [1:0] sel);
		int hz;
		unique case (sel)
			2'h0: hz = SPI_HZ_0;
			2'h1: hz = SPI_HZ_1;
			2'h2: hz = SPI_HZ_2;
			2'h3: hz = SPI_HZ_3;
		endcase
		return CNT_W'((LINK_HZ + 2 * hz - 1) / (2 * hz));
	endfunction : spi_half

	// one character bit in link cycles
	function automatic logic [CNT_W-1:0] baud_bit(input logic [1:0] sel);
		int bd;
		unique case (sel)
			2'h0: bd = BAUD_0;
			2'h1: bd = BAUD_1;
			2'h2: bd = BAUD_2;
			2'h3: bd = BAUD_3;
		endcase
		return CNT_W'(LINK_HZ / bd);
	endfunction : baud_bit

endpackage : aux_port_pkg

/* File: src/sync3.sv */
`timescale 1ns/10ps
`default_nettype none
module sync3 #(
	parameter int W = 1
) (
	input  wire logic         clk_in,
	input  wire logic         rst_in,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} sync_t;

	sync_t sq;
	sync_t sd;

	// second and third stage must agree before the output follows
	always_comb begin
		sd    = sq;
		sd.s1 = d_in;
		sd.s2 = sq.s1;
		sd.s3 = sq.s2;
		if (sq.s2 == sq.s3) begin
			sd.q = sq.s3;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			sq <= '0;
		end else begin
			sq <= sd;
		end
	end

	assign q_out = sq.q;

endmodule : sync3
`default_nettype wire

/* File: src/async_rx.sv */
`timescale 1ns/10ps
`default_nettype none
module async_rx (
	input  wire logic                   clk_in,
	input  wire logic                   rst_in,
	input  wire logic                   rxd_in,
	input  wire aux_port_pkg::link_cfg_t cfg_in,
	output logic                  [7:0] byte_out,
	output logic                        err_out,
	output logic                        tgl_out
);
	import aux_port_pkg::*;

	typedef struct packed {
		logic             busy;
		logic [CNT_W-1:0] cnt;
		logic [3:0]       steps;
		logic [7:0]       sh;
		logic             par;
		logic             tgl;
		logic [7:0]       data;
		logic             err;
	} rx_t;

	rx_t rq;
	rx_t rd;

	// start detect, mid-bit sampling, parity and stop check
	always_comb begin
		rd = rq;
		if (!rq.busy) begin
			if (cfg_in.mode == MODE_ASYNC && !rxd_in) begin
				rd.busy  = 1'b1;
				rd.steps = 4'h0;
				rd.par   = cfg_in.par_odd;
				rd.cnt   = baud_bit(cfg_in.baud) >> 1;
			end
		end else if (rq.cnt > 1) begin
			rd.cnt = rq.cnt - 1'b1;
		end else begin
			rd.cnt   = baud_bit(cfg_in.baud);
			rd.steps = rq.steps + 4'h1;
			if (rq.steps == 4'h0) begin
				rd.busy = !rxd_in; // glitch: drop the frame
			end else if (rq.steps <= 4'h8) begin
				rd.sh  = {rxd_in, rq.sh[7:1]};
				rd.par = rq.par ^ rxd_in;
			end else if (rq.steps == 4'h9 && cfg_in.par_en) begin
				rd.par = rq.par ^ rxd_in;
			end else begin
				rd.busy = 1'b0;
				rd.tgl  = !rq.tgl;
				rd.data = rq.sh;
				rd.err  = !rxd_in || (cfg_in.par_en && rq.par);
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			rq <= '0;
		end else begin
			rq <= rd;
		end
	end

	assign byte_out = rq.data;
	assign err_out  = rq.err;
	assign tgl_out  = rq.tgl;

endmodule : async_rx
`default_nettype wire

/* File: src/aux_port_ctrl.sv */
// Function
// [R1] port commands are honoured only while the host uses the parallel bus
// [R2] in general mode each of the seven lines is input or output
// [R3] general mode offers configure, drive levels and sample levels
// [R4] configuration byte top two bits choose the port mode
// [R5] top bit set: general mode, low seven bits are directions
// [R6] a general mode configuration drives every line low
// [R7] synchronous send exchanges one byte out and one byte in
// [R8] synchronous received byte is held until the host reads it
// [R9] buffered send takes up to 128 bytes; last received byte kept
// [R10] synchronous mode fixes clock, data, busy and select line roles
// [R11] idle clock level, active edge and rate shape synchronous transfers
// [R12] with busy wait on, the host busy line is checked before sending
// [R13] synchronous data leaves most significant bit first
// [R14] a transmit done flag is readable by status read in serial modes
// [R15] asynchronous send is one character; receive holds one byte
// [R16] asynchronous buffered send queues up to 128 bytes
// [R17] asynchronous mode fixes transmit, receive, busy and select roles
// [R18] asynchronous module busy line follows the receive full flag
// [R19] two low bits pick 4 MHz, 1 MHz, 250 kHz or 125 kHz
// [R20] two low bits pick 4800 to 38400 baud; two bits pick parity
// [R21] status read clears the transmit done flag
// [R22] sending waits while the far side holds the host busy line high; the code waits only when the busy wait bit is set
`timescale 1ns/10ps
`default_nettype none
module aux_port_ctrl (
	input  wire logic                  clk_in,
	input  wire logic                  rst_in,
	input  wire logic                  link_clk_in,
	input  wire logic                  parallel_attached_in,
	input  wire aux_port_pkg::host_wr_t host_wr_in,
	input  wire logic                  host_rd_in,
	output logic                 [7:0] host_rd_data_out,
	output logic                       host_full_out,
	input  wire logic            [6:0] line_in,
	output logic                 [6:0] line_out,
	output logic                 [6:0] line_oe_n_out
);
	import aux_port_pkg::*;

	// ------------------------------------------------------------------
	// host side state
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {P_IDLE, P_CFG, P_SEND, P_SIZE, P_DATA} parse_t;
	typedef enum logic [1:0] {RK_NONE, RK_STATUS, RK_DATA} rd_kind_t;

	typedef struct packed {
		port_mode_t             mode;
		logic [7:0]             cfg;
		logic [6:0]             dir;
		logic [6:0]             lvl;
		parse_t                 ps;
		logic [7:0]             left;
		logic [7:0]             rd;
		rd_kind_t               kind;
		logic                   transmit_done_flag;
		logic                   receive_full_flag;
		logic                   err;
		logic [7:0]             rx_hold;
		logic [127:0][7:0]      q;
		logic [6:0]             wp;
		logic [6:0]             rp;
		logic [7:0]             cnt;
		logic [7:0]             tx_byte;
		logic                   start_tgl;
		logic                   busy;
		logic                   done_seen;
		logic                   rxt_seen;
	} ctl_t;

	// ------------------------------------------------------------------
	// link side state
	// ------------------------------------------------------------------
	typedef struct packed {
		logic             ack;
		logic             busy;
		logic [CNT_W-1:0] cnt;
		logic [4:0]       steps;
		logic [10:0]      sh;
		logic [7:0]       rx;
		logic             sck;
		logic             txd;
		logic             done_tgl;
	} link_t;

	ctl_t      cq;
	ctl_t      cn;
	link_t     lq;
	link_t     ln;
	logic [1:0] lrst_q;
	logic       lrst;
	link_cfg_t  cfg_w;
	link_cfg_t  lcfg;
	logic       start_s;
	logic [6:0] line_s;
	logic [1:0] ev_s;
	logic [1:0] pin_s;
	logic [7:0] arx_byte;
	logic       arx_err;
	logic       arx_tgl;
	logic       hb_s;
	logic       pend;
	logic       push;
	logic       pop;

	// ------------------------------------------------------------------
	// crossings
	// ------------------------------------------------------------------
	// reset carried into the link domain
	always_ff @(posedge link_clk_in) begin
		lrst_q <= {lrst_q[0], rst_in};
	end
	assign lrst = lrst_q[1];

	// mode bits decoded for the link logic
	always_comb begin
		cfg_w           = '0;
		cfg_w.mode      = cq.mode;
		cfg_w.idle_hi   = cq.cfg[CFG_IDLE_CLK_BIT];
		cfg_w.edge_rise = cq.cfg[CFG_EDGE_BIT];
		cfg_w.speed     = cq.cfg[1:0]; // R19
		cfg_w.par_en    = cq.cfg[CFG_PAR_EN_BIT]; // R20
		cfg_w.par_odd   = cq.cfg[CFG_PAR_ODD_BIT];
		cfg_w.baud      = cq.cfg[1:0]; // R20
	end

	sync3 #(.W($bits(link_cfg_t) + 1)) u_to_link (
		.clk_in (link_clk_in),
		.rst_in (lrst),
		.d_in   ({cq.start_tgl, cfg_w}),
		.q_out  ({start_s, lcfg})
	);

	sync3 #(.W(2)) u_link_pins (
		.clk_in (link_clk_in),
		.rst_in (lrst),
		.d_in   ({line_in[LN_MISO], line_in[LN_RXD]}),
		.q_out  (pin_s)
	);

	sync3 #(.W(NUM_LINES)) u_host_pins (
		.clk_in (clk_in),
		.rst_in (rst_in),
		.d_in   (line_in),
		.q_out  (line_s)
	);

	sync3 #(.W(2)) u_events (
		.clk_in (clk_in),
		.rst_in (rst_in),
		.d_in   ({lq.done_tgl, arx_tgl}),
		.q_out  (ev_s)
	);

	async_rx u_async_rx (
		.clk_in   (link_clk_in),
		.rst_in   (lrst),
		.rxd_in   (pin_s[0]),
		.cfg_in   (lcfg),
		.byte_out (arx_byte),
		.err_out  (arx_err),
		.tgl_out  (arx_tgl)
	);

	assign hb_s = line_s[LN_HB];
	assign pend = (cq.cnt != 8'h00) || cq.busy;
	assign host_full_out = (cq.cnt == BUF_DEPTH);

	// ------------------------------------------------------------------
	// command parser, queue and flags
	// ------------------------------------------------------------------
	always_comb begin
		cn   = cq;
		push = 1'b0;
		pop  = 1'b0;
		// read side effects come first so a same-cycle set wins
		if (host_rd_in && cq.kind == RK_STATUS) begin
			cn.transmit_done_flag = 1'b0; // R21
			cn.err = 1'b0;
		end
		if (host_rd_in && cq.kind == RK_DATA) begin
			cn.receive_full_flag = 1'b0; // R8
		end
		if (host_rd_in) begin
			cn.kind = RK_NONE;
		end
		if (host_wr_in.valid && parallel_attached_in) begin // R1
			if (!host_wr_in.rs) begin
				cn.ps = P_IDLE;
				case (host_wr_in.data)
					CMD_CONFIGURE: cn.ps = P_CFG; // R3
					CMD_SEND: cn.ps = P_SEND; // R3
					CMD_BUF_SEND: begin
						if (cq.mode != MODE_IO) begin
							cn.ps = P_SIZE; // R9 R16
						end
					end
					CMD_STATUS: begin
						cn.kind = RK_STATUS; // R14
						cn.rd   = {3'h0, hb_s, pend, cq.transmit_done_flag, cq.receive_full_flag,
							(cq.mode == MODE_ASYNC) && cq.err};
					end
					CMD_READ: begin
						cn.kind = RK_DATA;
						cn.rd   = (cq.mode == MODE_IO) ?
							{1'b0, line_s} : cq.rx_hold; // R3 R8 R15
					end
					default: ;
				endcase
			end else begin
				unique case (cq.ps)
					P_IDLE: ;
					P_CFG: begin
						cn.cfg = host_wr_in.data;
						cn.ps  = P_IDLE;
						if (host_wr_in.data[CFG_IO_BIT]) begin // R4
							cn.mode = MODE_IO; // R5
							cn.dir  = host_wr_in.data[6:0]; // R2 R5
							cn.lvl  = 7'h00; // R6
						end else if (host_wr_in.data[CFG_ASYNC_BIT]) begin
							cn.mode = MODE_ASYNC; // R4
						end else begin
							cn.mode = MODE_SYNC; // R4
						end
					end
					P_SEND: begin
						cn.ps = P_IDLE;
						if (cq.mode == MODE_IO) begin
							cn.lvl = host_wr_in.data[6:0]; // R3
						end else begin
							push = 1'b1; // R7 R15
						end
					end
					P_SIZE: begin
						cn.left = (host_wr_in.data > BUF_DEPTH) ?
							BUF_DEPTH : host_wr_in.data; // R9 R16
						cn.ps = (host_wr_in.data == 8'h00) ? P_IDLE : P_DATA;
					end
					P_DATA: begin
						push    = 1'b1;
						cn.left = cq.left - 8'h01;
						if (cq.left == 8'h01) begin
							cn.ps = P_IDLE;
						end
					end
				endcase
			end
		end
		// next byte to the link once buffering ended and far side is ready
		if (!cq.busy && cq.cnt != 8'h00 && cq.ps != P_DATA &&
			cq.mode != MODE_IO &&
			(!cq.cfg[CFG_BUSY_WAIT] || !hb_s)) begin // R12 R22
			pop          = 1'b1;
			cn.tx_byte   = cq.q[cq.rp];
			cn.rp        = cq.rp + 7'h01;
			cn.start_tgl = !cq.start_tgl;
			cn.busy      = 1'b1;
		end
		if (push && !host_full_out) begin
			cn.q[cq.wp] = host_wr_in.data;
			cn.wp       = cq.wp + 7'h01;
		end
		cn.cnt = cq.cnt + {7'h00, push && !host_full_out} - {7'h00, pop};
		// transfer finished on the link
		if (ev_s[1] != cq.done_seen) begin
			cn.done_seen = ev_s[1];
			cn.busy      = 1'b0;
			cn.transmit_done_flag       = 1'b1; // R14
			if (cq.mode == MODE_SYNC) begin
				cn.rx_hold = lq.rx; // R7 R9
				cn.receive_full_flag     = 1'b1;
			end
		end
		// character arrived on the receive line
		if (ev_s[0] != cq.rxt_seen) begin
			cn.rxt_seen = ev_s[0];
			if (cq.mode == MODE_ASYNC) begin
				cn.rx_hold = arx_byte; // R15
				cn.receive_full_flag     = 1'b1;
				cn.err     = cq.err || arx_err || cq.receive_full_flag;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cq      <= '0;
			cq.mode <= MODE_IO;
			cq.dir  <= RST_LINE_DIR;
		end else begin
			cq <= cn;
		end
	end

	assign host_rd_data_out = cq.rd;

	// ------------------------------------------------------------------
	// link shifter: clocked serial exchange or character transmit
	// ------------------------------------------------------------------
	always_comb begin
		ln = lq;
		if (!lq.busy) begin
			ln.sck = lcfg.idle_hi; // R11
			ln.txd = 1'b1;
			if (start_s != lq.ack) begin
				ln.ack   = start_s;
				ln.busy  = 1'b1;
				ln.steps = 5'h00;
				if (lcfg.mode == MODE_SYNC) begin
					ln.cnt = spi_half(lcfg.speed); // R19
					ln.sh  = {3'h0, cq.tx_byte};
				end else begin
					ln.cnt = baud_bit(lcfg.baud); // R20
					ln.sh  = {2'b11, !lcfg.par_en || (lcfg.par_odd ^
						(^cq.tx_byte)), cq.tx_byte};
					ln.txd = 1'b0;
				end
			end
		end else if (lq.cnt > 1) begin
			ln.cnt = lq.cnt - 1'b1;
		end else if (lcfg.mode == MODE_SYNC) begin
			ln.cnt   = spi_half(lcfg.speed);
			ln.steps = lq.steps + 5'h01;
			if (lq.steps == 5'h10) begin
				ln.busy     = 1'b0;
				ln.done_tgl = !lq.done_tgl;
			end else begin
				ln.sck = !lq.sck;
				if (!lq.sck == lcfg.edge_rise) begin // R11
					ln.rx = {lq.rx[6:0], pin_s[1]}; // R7
				end else if (lq.steps != 5'h00) begin
					ln.sh = {lq.sh[9:0], 1'b0}; // R13
				end
			end
		end else begin
			ln.cnt   = baud_bit(lcfg.baud);
			ln.steps = lq.steps + 5'h01;
			if (lq.steps == (lcfg.par_en ? 5'h0a : 5'h09)) begin
				ln.busy     = 1'b0;
				ln.done_tgl = !lq.done_tgl;
			end else begin
				ln.txd = lq.sh[0]; // R15
				ln.sh  = {1'b1, lq.sh[10:1]};
			end
		end
	end

	always_ff @(posedge link_clk_in) begin
		if (lrst) begin
			lq <= '0;
		end else begin
			lq <= ln;
		end
	end

	// ------------------------------------------------------------------
	// connector line roles per mode
	// ------------------------------------------------------------------
	always_comb begin
		line_out      = 7'h00;
		line_oe_n_out = 7'h7f;
		unique case (cq.mode)
			MODE_IO: begin
				line_out      = cq.lvl; // R2
				line_oe_n_out = cq.dir; // R2 R5
			end
			MODE_SYNC: begin
				line_out[LN_SCK]       = lq.sck; // R10
				line_out[LN_MOSI]      = lq.sh[7]; // R13
				line_out[LN_MB]        = pend;
				line_out[LN_TXD]       = cq.cfg[CFG_LEVEL_BIT];
				line_oe_n_out[LN_SCK]  = 1'b0; // R10
				line_oe_n_out[LN_MOSI] = 1'b0;
				line_oe_n_out[LN_MB]   = 1'b0;
				line_oe_n_out[LN_TXD]  = 1'b0;
			end
			MODE_ASYNC: begin
				line_out[LN_TXD]       = lq.txd; // R17
				line_out[LN_MB]        = cq.receive_full_flag; // R18
				line_out[LN_MISO]      = cq.cfg[CFG_LEVEL_BIT];
				line_oe_n_out[LN_TXD]  = 1'b0; // R17
				line_oe_n_out[LN_MB]   = 1'b0;
				line_oe_n_out[LN_MISO] = 1'b0;
			end
			default: ;
		endcase
	end

endmodule : aux_port_ctrl
`default_nettype wire

/* File: tb/aux_port_ctrl_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
// ------------------------------
// port checker
// ------------------------------
module aux_port_ctrl_chk (
	input  wire logic                   clk_in,
	input  wire logic                   rst_in,
	input  wire logic                   link_clk_in,
	input  wire logic                   parallel_attached_in,
	input  wire aux_port_pkg::host_wr_t host_wr_in,
	input  wire logic                   host_rd_in,
	input  wire logic             [7:0] host_rd_data_out,
	input  wire logic                   host_full_out,
	input  wire logic             [6:0] line_in,
	input  wire logic             [6:0] line_out,
	input  wire logic             [6:0] line_oe_n_out
);
	import aux_port_pkg::*;
	logic [7:0] cmd_q, cfg_q, wd;
	logic [6:0] lin_q;
	logic [2:0] stab_q;
	logic       set_q, acc, par, pcf, io, sy, asy;
	// accepted writes and the mode last configured
	assign wd  = host_wr_in.data;
	assign acc = host_wr_in.valid && parallel_attached_in;
	assign par = acc && host_wr_in.rs;
	assign pcf = par && cmd_q == CMD_CONFIGURE;
	assign io  = !set_q || cfg_q[7];
	assign sy  = set_q && cfg_q[7:6] == 2'h0;
	assign asy = set_q && cfg_q[7:6] == 2'h1;
	// track pending command, config byte and pin stability
	always_ff @(posedge clk_in) begin
		lin_q <= line_in;
		if (rst_in || line_in != lin_q) begin
			stab_q <= 3'h0;
		end else if (stab_q != 3'h7) begin
			stab_q <= stab_q + 3'h1;
		end
		if (rst_in) begin
			cmd_q <= 8'h00;
			cfg_q <= 8'h00;
			set_q <= 1'b0;
		end else if (acc && !host_wr_in.rs) begin
			cmd_q <= wd;
		end else if (pcf) begin
			cmd_q <= 8'h00;
			cfg_q <= wd;
			set_q <= 1'b1;
		end else if (par && cmd_q == CMD_SEND) begin
			cmd_q <= 8'h00;
		end
	end
	default clocking dc @(posedge clk_in);
	endclocking
	default disable iff (rst_in);
	AST_IO_CFG:
	assert property (pcf && wd[7] |=> line_oe_n_out == $past(wd[6:0])
		&& line_out == 7'h00) else $error("io config wrong");
	AST_HOLD_OE:
	assert property (!par |=> $stable(line_oe_n_out))
		else $error("directions changed");
	AST_SYNC_ROLES:
	assert property (sy |-> (line_oe_n_out & 7'h7d) == 7'h48)
		else $error("sync roles wrong");
	AST_ASYNC_ROLES:
	assert property (asy |-> (line_oe_n_out & 7'h7a) == 7'h42)
		else $error("async roles wrong");
	AST_MB_CLEAR:
	assert property (asy && cmd_q == CMD_READ && host_rd_in
		|-> ##[1:4] !line_out[LN_MB]) else $error("busy not cleared");
	AST_IO_READ:
	assert property (io && acc && !host_wr_in.rs && wd == CMD_READ
		&& stab_q > 3'h4 |=> host_rd_data_out[6:0] == $past(line_in))
		else $error("io read wrong");
	AST_IO_DRIVE:
	assert property (io && par && cmd_q == CMD_SEND |=> (line_out
		& ~line_oe_n_out) == ($past(wd[6:0]) & ~line_oe_n_out))
		else $error("io drive wrong");
	AST_IDLE_CLK:
	assert property (pcf && wd[7:6] == 2'h0 |-> ##16 line_out[LN_SCK]
		== $past(wd[CFG_IDLE_CLK_BIT], 16)) else $error("idle clock wrong");
	AST_SEL_LEVEL:
	assert property (pcf && !wd[7] |=> (sy ? line_out[LN_TXD] :
		line_out[LN_MISO]) == $past(wd[CFG_LEVEL_BIT]))
		else $error("select level wrong");
	cover property (sy && par && cmd_q == CMD_SEND);
	cover property (asy && $rose(line_out[LN_MB]));
	cover property (host_full_out);
endmodule : aux_port_ctrl_chk

bind aux_port_ctrl aux_port_ctrl_chk u_chk (
	.clk_in(clk_in), .rst_in(rst_in), .link_clk_in(link_clk_in),
	.parallel_attached_in(parallel_attached_in), .host_wr_in(host_wr_in),
	.host_rd_in(host_rd_in), .host_rd_data_out(host_rd_data_out),
	.host_full_out(host_full_out), .line_in(line_in),
	.line_out(line_out), .line_oe_n_out(line_oe_n_out)
);
`default_nettype wire

/* File: tb/far_end_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ------------------------------
// far end: spi slave, character sender, busy source
// ------------------------------
module far_end_model #(
	parameter int BIT_CYC = 325
) (
	input  wire logic        link_clk_in,
	input  wire logic        sck_in,
	input  wire logic        mosi_in,
	input  wire logic        busy_in,
	input  wire logic [6:0]  pat_in,
	output logic      [6:0]  far_out,
	output logic      [15:0] got_out,
	output logic      [7:0]  cnt_out
);
	logic [7:0] tx_q = 8'h3c;
	logic [7:0] rx_q = 8'h00;
	logic       rxd_q = 1'b1;
	int         nb = 0;
	initial got_out = 16'h0000;
	initial cnt_out = 8'h00;
	// busy level is set by the bench
	assign far_out = {busy_in, pat_in[5:4], tx_q[7], pat_in[2], rxd_q, pat_in[0]};
	// take master data on the rising edge, msb first
	always @(posedge sck_in) begin
		rx_q = {rx_q[6:0], mosi_in};
		nb = nb + 1;
	end
	// shift reply on falling edge, new reply after a byte
	always @(negedge sck_in) begin
		if (nb == 8) begin
			nb = 0;
			got_out = {got_out[7:0], rx_q};
			cnt_out = cnt_out + 8'h01;
			tx_q = 8'h3c + cnt_out;
		end else begin
			tx_q = {tx_q[6:0], 1'b0};
		end
	end
	// start, eight data bits lsb first, stop
	task automatic send_char(input logic [7:0] b);
		logic [9:0] fr;
		fr = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			#1 rxd_q = fr[i];
			repeat (BIT_CYC) @(posedge link_clk_in);
		end
	endtask : send_char
endmodule : far_end_model
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import aux_port_pkg::*;
	// ------------------------------
	// stimulus and wiring
	// ------------------------------
	logic        clk_in = 1'b0;
	logic        link_clk = 1'b0;
	logic        rst_in = 1'b1;
	logic        attached = 1'b1;
	host_wr_t    wr_s = '0;
	logic        rd_s = 1'b0;
	logic        hb = 1'b0;
	logic [6:0]  pat = 7'h34;
	wire  logic [7:0]  rd_data;
	wire  logic        host_full;
	wire  logic [6:0]  lout, loe, lin, far;
	wire  logic [15:0] got;
	wire  logic [7:0]  cnt;
	int          n_fail = 0;
	int          num_checks = 0;
	int          cyc = 0;
	// host clock and free-running link clock
	always #20 clk_in = ~clk_in;
	always #40 link_clk = ~link_clk;
	// pin level from whoever drives it
	assign lin = (lout & ~loe) | (far & loe);
	aux_port_ctrl u_dut (
		.clk_in(clk_in), .rst_in(rst_in), .link_clk_in(link_clk),
		.parallel_attached_in(attached), .host_wr_in(wr_s),
		.host_rd_in(rd_s), .host_rd_data_out(rd_data),
		.host_full_out(host_full), .line_in(lin), .line_out(lout),
		.line_oe_n_out(loe)
	);
	far_end_model #(.BIT_CYC(LINK_HZ / BAUD_3)) u_far (
		.link_clk_in(link_clk), .sck_in(lin[LN_SCK]), .mosi_in(lin[LN_MOSI]),
		.busy_in(hb), .pat_in(pat), .far_out(far), .got_out(got), .cnt_out(cnt)
	);
	// ------------------------------
	// shared tasks
	// ------------------------------
	task automatic chk(input string what, input logic [7:0] exp,
		input logic [7:0] seen);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic rs, input logic [7:0] d);
		@(posedge clk_in);
		#1 wr_s = {1'b1, rs, d};
		@(posedge clk_in);
		#1 wr_s.valid = 1'b0;
	endtask : wr
	task automatic rd_strobe();
		@(posedge clk_in);
		#1 rd_s = 1'b1;
		@(posedge clk_in);
		#1 rd_s = 1'b0;
	endtask : rd_strobe
	task automatic cfg(input logic [7:0] v);
		wr(1'b0, CMD_CONFIGURE);
		wr(1'b1, v);
	endtask : cfg
	task automatic wait_flag(input int b, input int lim);
		wr(1'b0, CMD_STATUS);
		for (int i = 0; i < lim && rd_data[b] !== 1'b1; i++) begin
			wr(1'b0, CMD_STATUS);
		end
	endtask : wait_flag
	task automatic do_reset();
		rst_in = 1'b1;
		repeat (10) @(posedge clk_in);
		#1 rst_in = 1'b0;
	endtask : do_reset
	// ------------------------------
	// scenarios
	// ------------------------------
	task automatic t_io();
		attached = 1'b0;
		cfg(8'h80);
		chk("detached", 8'h7f, {1'b0, loe});
		attached = 1'b1;
		cfg(8'ha9);
		chk("io dirs", 8'h29, {1'b0, loe});
		chk("io low", 8'h00, {1'b0, lout});
		wr(1'b0, CMD_SEND);
		wr(1'b1, 8'h56);
		chk("io drive", 8'h56, {1'b0, lout & ~loe});
		repeat (6) @(posedge clk_in);
		wr(1'b0, CMD_READ);
		chk("io sample", 8'h76, {1'b0, rd_data[6:0]});
	endtask : t_io
	task automatic t_sync();
		do_reset();
		cfg(8'h05);
		chk("sync roles", 8'h48, {1'b0, loe & 7'h7d});
		wr(1'b0, CMD_SEND);
		wr(1'b1, 8'ha5);
		wait_flag(ST_TXC_BIT, 400);
		chk("sync done", 8'h01, {7'h0, rd_data[ST_TXC_BIT]});
		chk("sync rxc", 8'h01, {7'h0, rd_data[ST_RXC_BIT]});
		chk("byte out", 8'ha5, got[7:0]);
		wr(1'b0, CMD_READ);
		chk("byte in", 8'h3c, rd_data);
		repeat (2) begin
			rd_strobe();
			wr(1'b0, CMD_STATUS);
		end
		chk("txc clear", 8'h00, {7'h0, rd_data[ST_TXC_BIT]});
	endtask : t_sync
	task automatic t_wait();
		hb = 1'b1;
		cfg(8'h15);
		wr(1'b0, CMD_SEND);
		wr(1'b1, 8'h5a);
		repeat (300) @(posedge clk_in);
		wr(1'b0, CMD_STATUS);
		chk("held st", 8'h18, rd_data & 8'h1c);
		chk("held cnt", 8'h01, cnt);
		hb = 1'b0;
		wait_flag(ST_TXC_BIT, 400);
		chk("released", 8'h5a, got[7:0]);
	endtask : t_wait
	task automatic t_burst();
		cfg(8'h05);
		wr(1'b0, CMD_BUF_SEND);
		wr(1'b1, 8'h03);
		wr(1'b1, 8'h11);
		wr(1'b1, 8'h22);
		wr(1'b1, 8'h33);
		for (int i = 0; i < 2000 && cnt != 8'h05; i++) @(posedge clk_in);
		repeat (40) @(posedge clk_in);
		chk("burst order", 8'h22, got[15:8]);
		chk("burst last", 8'h33, got[7:0]);
		wr(1'b0, CMD_READ);
		chk("burst reply", 8'h40, rd_data);
	endtask : t_burst
	task automatic t_full();
		hb = 1'b1;
		cfg(8'h15);
		wr(1'b0, CMD_BUF_SEND);
		wr(1'b1, 8'hff);
		for (int i = 0; i < 127; i++) wr(1'b1, 8'(i));
		chk("not full", 8'h00, {7'h0, host_full});
		wr(1'b1, 8'h7f);
		chk("full", 8'h01, {7'h0, host_full});
		cfg(8'h1d);
		repeat (16) @(posedge clk_in);
		chk("idle sck", 8'h01, {7'h0, lout[LN_SCK]});
	endtask : t_full
	task automatic t_async();
		do_reset();
		hb = 1'b0;
		cfg(8'h43);
		chk("async roles", 8'h42, {1'b0, loe & 7'h7a});
		u_far.send_char(8'hc6);
		for (int i = 0; i < 400 && lout[LN_MB] !== 1'b1; i++) @(posedge clk_in);
		chk("mb set", 8'h01, {7'h0, lout[LN_MB]});
		wr(1'b0, CMD_READ);
		chk("char in", 8'hc6, rd_data);
		rd_strobe();
		repeat (4) @(posedge clk_in);
		chk("mb clear", 8'h00, {7'h0, lout[LN_MB]});
		wr(1'b0, CMD_SEND);
		wr(1'b1, 8'h81);
		wait_flag(ST_TXC_BIT, 5000);
		chk("char sent", 8'h01, {7'h0, rd_data[ST_TXC_BIT]});
	endtask : t_async
	// ------------------------------
	// run control
	// ------------------------------
	task automatic wrap_up();
		$display("checks %0d failures %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : wrap_up
	// cut a hang short
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 60000) begin
			n_fail++;
			wrap_up();
		end
	end
	// main sequence
	initial begin
		do_reset();
		chk("rst oe", 8'h7f, {1'b0, loe});
		chk("rst rd", 8'h00, rd_data);
		t_io();
		t_sync();
		t_wait();
		t_burst();
		t_full();
		t_async();
		wrap_up();
	end
endmodule : testbench
`default_nettype wire
